// ---- logic/irp_top.sv ----
// Purpose: interrupt request and priority-enable register bank with AXI4-Lite access
// Assumes: source pulses and core strobes are synchronous to i_sys_clk
// Notes: port C sources have no priority pair here and are reachable by polling only
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "irp_regs.svh"

module irp_top #(
	parameter int ADDR_W = 16
) (
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_nrst,
	input  wire logic [ADDR_W-1:0]     i_awaddr,
	input  wire logic                  i_awvalid,
	output logic                       o_awready,
	input  wire logic [31:0]           i_wdata,
	input  wire logic [3:0]            i_wstrb,
	input  wire logic                  i_wvalid,
	output logic                       o_wready,
	output logic [1:0]                 o_bresp,
	output logic                       o_bvalid,
	input  wire logic                  i_bready,
	input  wire logic [ADDR_W-1:0]     i_araddr,
	input  wire logic                  i_arvalid,
	output logic                       o_arready,
	output logic [31:0]                o_rdata,
	output logic [1:0]                 o_rresp,
	output logic                       o_rvalid,
	input  wire logic                  i_rready,
	input  wire irp_pkg::irp_src_t     i_src,
	input  wire logic                  i_gie_set,
	input  wire logic                  i_gie_clr,
	input  wire logic                  i_irq_ack,
	output irp_pkg::irp_core_req_t     o_core,
	output logic                       o_global_int_enable
);

	generate
		if (ADDR_W < `IRP_IDX_W + 3) begin : g_chk
			$error("irp_top: ADDR_W too small for the register map");
		end
	endgenerate

	// register state
	logic [7:0]                  pending_group0_r;
	logic [7:0]                  pending_group1_r;
	logic [7:0]                  pending_group2_r;
	logic [7:0]                  group0_prio_hi_r;
	logic [7:0]                  group0_prio_lo_r;
	logic [7:0]                  group1_prio_hi_r;
	logic [7:0]                  group1_prio_lo_r;
	logic                        global_int_enable_r;
	irp_pkg::irp_core_req_t      core_r;

	// bus state
	logic                        aw_have_r;
	logic                        w_have_r;
	logic [ADDR_W-1:0]           awaddr_r;
	logic [7:0]                  wbyte_r;
	logic                        wlane_r;
	logic                        bvalid_r;
	logic [1:0]                  bresp_r;
	logic                        rvalid_r;
	logic [1:0]                  rresp_r;
	logic [31:0]                 rdata_r;

	// write decode
	logic                        wr_fire;
	logic                        wr_hit;
	logic [`IRP_IDX_W-1:0]       wr_idx;
	logic                        wr_pend0;
	logic                        wr_pend1;
	logic                        wr_pend2;
	logic                        wr_ctrl;

	// per-source view in fixed order
	logic [`IRP_NUM_SRC-1:0]     src_pend;
	logic [`IRP_NUM_SRC-1:0]     src_hi;
	logic [`IRP_NUM_SRC-1:0]     src_lo;
	logic [`IRP_NUM_SRC-1:0]     ack_onehot;
	logic [7:0]                  g0_clr;
	logic [7:0]                  g1_clr;
	logic [7:0]                  g2_clr;
	logic [7:0]                  g0_set;
	logic [7:0]                  g1_set;
	logic [7:0]                  g2_set;
	logic [7:0]                  pend0_nxt;
	logic [7:0]                  pend1_nxt;
	logic [7:0]                  pend2_nxt;
	logic                        best_found;
	logic [4:0]                  best_idx;
	irp_pkg::irp_lvl_t           best_lvl;
	logic                        ack_take;

	// read decode
	logic                        rd_hit;
	logic [7:0]                  rd_byte;
	logic [`IRP_IDX_W-1:0]       rd_idx;

	assign o_awready           = ~aw_have_r & ~bvalid_r;
	assign o_wready            = ~w_have_r & ~bvalid_r;
	assign o_bvalid            = bvalid_r;
	assign o_bresp             = bresp_r;
	assign o_arready           = ~rvalid_r;
	assign o_rvalid            = rvalid_r;
	assign o_rresp             = rresp_r;
	assign o_rdata             = rdata_r;
	assign o_core              = core_r;
	assign o_global_int_enable = global_int_enable_r;

	// write channel capture, either order
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			aw_have_r <= 1'b0;
			awaddr_r  <= '0;
		end else if (i_awvalid && o_awready) begin
			aw_have_r <= 1'b1;
			awaddr_r  <= i_awaddr;
		end else if (wr_fire) begin
			aw_have_r <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			w_have_r <= 1'b0;
			wbyte_r  <= `IRP_RST_BYTE;
			wlane_r  <= 1'b0;
		end else if (i_wvalid && o_wready) begin
			w_have_r <= 1'b1;
			wbyte_r  <= i_wdata[7:0];
			wlane_r  <= i_wstrb[0];
		end else if (wr_fire) begin
			w_have_r <= 1'b0;
		end
	end

	assign wr_fire  = aw_have_r & w_have_r & ~bvalid_r;
	assign wr_idx   = awaddr_r[`IRP_IDX_W+1:2];
	assign wr_pend0 = wr_fire & wlane_r & (wr_idx == `IRP_IDX_PEND0);
	assign wr_pend1 = wr_fire & wlane_r & (wr_idx == `IRP_IDX_PEND1);
	assign wr_pend2 = wr_fire & wlane_r & (wr_idx == `IRP_IDX_PEND2);
	assign wr_ctrl  = wr_fire & wlane_r & (wr_idx == `IRP_IDX_CTRL);

	always_comb begin
		wr_hit = 1'b0;
		if (awaddr_r[ADDR_W-1:`IRP_IDX_W+2] == '0) begin
			case (wr_idx)
				`IRP_IDX_PEND0, `IRP_IDX_G0_HI, `IRP_IDX_G0_LO,
				`IRP_IDX_PEND1, `IRP_IDX_G1_HI, `IRP_IDX_G1_LO,
				`IRP_IDX_PEND2, `IRP_IDX_CTRL, `IRP_IDX_STAT: wr_hit = 1'b1;
				default: wr_hit = 1'b0;
			endcase
		end
	end

	// write response, unmapped answers slave error
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			bvalid_r <= 1'b0;
			bresp_r  <= `IRP_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wr_hit ? `IRP_RESP_OKAY : `IRP_RESP_SLVERR;
		end else if (i_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// fixed-order source view; port C has no priority pair
	always_comb begin
		src_pend = '0;
		src_hi   = '0;
		src_lo   = '0;
		src_pend[0] = pending_group0_r[`IRP_B_TIMER_B];
		src_pend[1] = pending_group0_r[`IRP_B_TIMER_A];
		src_pend[2] = pending_group0_r[`IRP_B_SERIAL_RX];
		src_pend[3] = pending_group0_r[`IRP_B_SERIAL_TX];
		src_pend[4] = pending_group0_r[`IRP_B_CONVERTER];
		src_hi[0] = group0_prio_hi_r[`IRP_B_TIMER_B];
		src_hi[1] = group0_prio_hi_r[`IRP_B_TIMER_A];
		src_hi[2] = group0_prio_hi_r[`IRP_B_SERIAL_RX];
		src_hi[3] = group0_prio_hi_r[`IRP_B_SERIAL_TX];
		src_hi[4] = group0_prio_hi_r[`IRP_B_CONVERTER];
		src_lo[0] = group0_prio_lo_r[`IRP_B_TIMER_B];
		src_lo[1] = group0_prio_lo_r[`IRP_B_TIMER_A];
		src_lo[2] = group0_prio_lo_r[`IRP_B_SERIAL_RX];
		src_lo[3] = group0_prio_lo_r[`IRP_B_SERIAL_TX];
		src_lo[4] = group0_prio_lo_r[`IRP_B_CONVERTER];
		for (int k = 0; k < 8; k++) begin
			src_pend[`IRP_SRC_G1_BASE+k] = pending_group1_r[7-k];
			src_hi[`IRP_SRC_G1_BASE+k]   = group1_prio_hi_r[7-k];
			src_lo[`IRP_SRC_G1_BASE+k]   = group1_prio_lo_r[7-k];
		end
		for (int k = 0; k < 4; k++) begin
			src_pend[`IRP_SRC_G2_BASE+k] = pending_group2_r[3-k];
		end
	end

	// level first, then lowest source number
	always_comb begin
		irp_pkg::irp_lvl_t lv;
		lv         = irp_pkg::IRP_LVL_OFF;
		best_found = 1'b0;
		best_idx   = '0;
		best_lvl   = irp_pkg::IRP_LVL_OFF;
		for (int i = 0; i < `IRP_NUM_SRC; i++) begin
			lv = irp_pkg::irp_lvl_t'({src_hi[i], src_lo[i]});
			if (src_pend[i] && lv > best_lvl) begin
				best_found = 1'b1;
				best_idx   = 5'(i);
				best_lvl   = lv;
			end
		end
	end

	// acknowledge clears the presented source
	assign ack_take = i_irq_ack & core_r.req;

	always_comb begin
		ack_onehot = '0;
		if (ack_take) begin
			ack_onehot[core_r.vec] = 1'b1;
		end
		g0_clr = '0;
		g1_clr = '0;
		g2_clr = '0;
		g0_clr[`IRP_B_TIMER_B]   = ack_onehot[0];
		g0_clr[`IRP_B_TIMER_A]   = ack_onehot[1];
		g0_clr[`IRP_B_SERIAL_RX] = ack_onehot[2];
		g0_clr[`IRP_B_SERIAL_TX] = ack_onehot[3];
		g0_clr[`IRP_B_CONVERTER] = ack_onehot[4];
		for (int k = 0; k < 8; k++) begin
			g1_clr[7-k] = ack_onehot[`IRP_SRC_G1_BASE+k];
		end
		for (int k = 0; k < 4; k++) begin
			g2_clr[3-k] = ack_onehot[`IRP_SRC_G2_BASE+k];
		end
	end

	// hardware pulses, always winning over clears
	always_comb begin
		g0_set = '0;
		g0_set[`IRP_B_TIMER_B]   = i_src.timer_b;
		g0_set[`IRP_B_TIMER_A]   = i_src.timer_a;
		g0_set[`IRP_B_SERIAL_RX] = i_src.serial_rx;
		g0_set[`IRP_B_SERIAL_TX] = i_src.serial_tx;
		g0_set[`IRP_B_CONVERTER] = i_src.converter;
		g1_set = i_src.porta_pin;
		g2_set = {4'h0, i_src.portc_pin};
	end

	// software write stores 0 or 1, then ack clear, then hardware set
	assign pend0_nxt = (((wr_pend0 ? wbyte_r : pending_group0_r) & ~g0_clr) | g0_set)
		& `IRP_MASK_G0;
	assign pend1_nxt = (((wr_pend1 ? wbyte_r : pending_group1_r) & ~g1_clr) | g1_set)
		& `IRP_MASK_G1;
	assign pend2_nxt = (((wr_pend2 ? wbyte_r : pending_group2_r) & ~g2_clr) | g2_set)
		& `IRP_MASK_G2;

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			pending_group0_r <= `IRP_RST_BYTE;
			pending_group1_r <= `IRP_RST_BYTE;
			pending_group2_r <= `IRP_RST_BYTE;
		end else begin
			pending_group0_r <= pend0_nxt;
			pending_group1_r <= pend1_nxt;
			pending_group2_r <= pend2_nxt;
		end
	end

	// priority pairs
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			group0_prio_hi_r <= `IRP_RST_BYTE;
			group0_prio_lo_r <= `IRP_RST_BYTE;
			group1_prio_hi_r <= `IRP_RST_BYTE;
			group1_prio_lo_r <= `IRP_RST_BYTE;
		end else if (wr_fire && wlane_r) begin
			case (wr_idx)
				`IRP_IDX_G0_HI: group0_prio_hi_r <= wbyte_r;
				`IRP_IDX_G0_LO: group0_prio_lo_r <= wbyte_r & `IRP_MASK_G0;
				`IRP_IDX_G1_HI: group1_prio_hi_r <= wbyte_r;
				`IRP_IDX_G1_LO: group1_prio_lo_r <= wbyte_r;
				default: ;
			endcase
		end
	end

	// global enable: set wins, acknowledge disables
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			global_int_enable_r <= 1'b0;
		end else if (i_gie_set || (wr_ctrl && wbyte_r[`IRP_B_GIE])) begin
			global_int_enable_r <= 1'b1;
		end else if (i_gie_clr || ack_take || wr_ctrl) begin
			global_int_enable_r <= 1'b0;
		end
	end

	// vectored request towards the core
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			core_r <= '{req: 1'b0, vec: 5'h00, level: irp_pkg::IRP_LVL_OFF};
		end else begin
			core_r.req   <= global_int_enable_r & best_found & ~ack_take;
			core_r.vec   <= best_idx;
			core_r.level <= best_lvl;
		end
	end

	// read decode; pending bits always visible for polling
	assign rd_idx = i_araddr[`IRP_IDX_W+1:2];

	always_comb begin
		rd_hit  = i_araddr[ADDR_W-1:`IRP_IDX_W+2] == '0;
		rd_byte = '0;
		case (rd_idx)
			`IRP_IDX_PEND0: rd_byte = pending_group0_r;
			`IRP_IDX_G0_HI: rd_byte = group0_prio_hi_r;
			`IRP_IDX_G0_LO: rd_byte = group0_prio_lo_r;
			`IRP_IDX_PEND1: rd_byte = pending_group1_r;
			`IRP_IDX_G1_HI: rd_byte = group1_prio_hi_r;
			`IRP_IDX_G1_LO: rd_byte = group1_prio_lo_r;
			`IRP_IDX_PEND2: rd_byte = pending_group2_r;
			`IRP_IDX_CTRL:  rd_byte = {global_int_enable_r, 7'h00};
			`IRP_IDX_STAT:  rd_byte = {core_r.req, core_r.level, core_r.vec};
			default:        rd_hit = 1'b0;
		endcase
	end

	// read answer, data stands until taken
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rvalid_r <= 1'b0;
			rresp_r  <= `IRP_RESP_OKAY;
			rdata_r  <= '0;
		end else if (i_arvalid && o_arready) begin
			rvalid_r <= 1'b1;
			rresp_r  <= rd_hit ? `IRP_RESP_OKAY : `IRP_RESP_SLVERR;
			rdata_r  <= rd_hit ? {24'h000000, rd_byte} : 32'h00000000;
		end else if (i_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// watchdog and oscillator-fail events have no port here

endmodule

// ---- logic/irp_regs.svh ----
// Purpose: register indices, field positions and reset values of the request/priority bank
// Assumes: byte address of a register is four times its index
// Notes: definitions only
`ifndef IRP_REGS_SVH
`define IRP_REGS_SVH

// register indices (word index, byte address = index * 4)
`define IRP_IDX_W          12
`define IRP_IDX_PEND0      12'hfc0
`define IRP_IDX_G0_HI      12'hfc1
`define IRP_IDX_G0_LO      12'hfc2
`define IRP_IDX_PEND1      12'hfc3
`define IRP_IDX_G1_HI      12'hfc4
`define IRP_IDX_G1_LO      12'hfc5
`define IRP_IDX_PEND2      12'hfc6
`define IRP_IDX_CTRL       12'hfcf
`define IRP_IDX_STAT       12'hfd0

// pending group 0 field positions, and the GIE bit of the control register
`define IRP_B_TIMER_B      6
`define IRP_B_TIMER_A      5
`define IRP_B_SERIAL_RX    4
`define IRP_B_SERIAL_TX    3
`define IRP_B_CONVERTER    0
`define IRP_B_GIE          7

// writable-bit masks and reset value
`define IRP_MASK_G0        8'h79
`define IRP_MASK_G1        8'hff
`define IRP_MASK_G2        8'h0f
`define IRP_RST_BYTE       8'h00

// source numbering, fixed order: 0 highest
`define IRP_SRC_G1_BASE    5
`define IRP_SRC_G2_BASE    13
`define IRP_NUM_SRC        17

// bus answers
`define IRP_RESP_OKAY      2'h0
`define IRP_RESP_SLVERR    2'h2

`endif

// ---- logic/irp_pkg.sv ----
// Purpose: types shared by the request/priority bank and its users
// Assumes: nothing beyond the register header
// Notes: no constants live here, only types
package irp_pkg;

	typedef struct packed {
		logic       timer_b;
		logic       timer_a;
		logic       serial_rx;
		logic       serial_tx;
		logic       converter;
		logic [7:0] porta_pin;
		logic [3:0] portc_pin;
	} irp_src_t;

	typedef enum logic [1:0] {
		IRP_LVL_OFF,
		IRP_LVL_1,
		IRP_LVL_2,
		IRP_LVL_3
	} irp_lvl_t;

	typedef struct packed {
		logic       req;
		logic [4:0] vec;
		irp_lvl_t   level;
	} irp_core_req_t;

endpackage

// ---- testbench/irp_top_properties.sv ----
// Purpose: concurrent checks on the request/priority bank ports
// Assumes: one clock, reset active low
// Notes: bound into irp_top
`timescale 1ns/1ps
module irp_top_checker (
	input wire logic                   i_sys_clk,
	input wire logic                   i_nrst,
	input wire logic                   i_arvalid,
	input wire logic                   o_arready,
	input wire logic                   o_rvalid,
	input wire logic                   i_gie_set,
	input wire logic                   i_gie_clr,
	input wire logic                   i_irq_ack,
	input wire irp_pkg::irp_core_req_t o_core,
	input wire logic                   o_global_int_enable
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);
	property p_reset_clear;
		$rose(i_nrst) |-> !o_core.req && !o_global_int_enable;
	endproperty
	property p_ack_clears;
		i_irq_ack && o_core.req && !i_gie_set |=> !o_core.req && !o_global_int_enable;
	endproperty
	property p_gie_set;
		i_gie_set |=> o_global_int_enable;
	endproperty
	property p_gie_clr;
		i_gie_clr && !i_gie_set |=> !o_global_int_enable;
	endproperty
	property p_req_needs_gie;
		!o_global_int_enable [*2] |-> !o_core.req;
	endproperty
	property p_req_level;
		o_core.req |-> o_core.level != irp_pkg::IRP_LVL_OFF;
	endproperty
	property p_no_portc_vec;
		o_core.req |-> o_core.vec <= 5'd12;
	endproperty
	property p_read_answer;
		i_arvalid && o_arready |=> o_rvalid;
	endproperty
	property p_req_stays;
		o_core.req && !i_irq_ack && o_global_int_enable |=> o_core.req;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear after reset");
	a_ack_clears: assert property (p_ack_clears) else $error("ack did not drop request");
	a_gie_set: assert property (p_gie_set) else $error("global enable not set");
	a_gie_clr: assert property (p_gie_clr) else $error("global enable not cleared");
	a_req_needs_gie: assert property (p_req_needs_gie) else $error("request while disabled");
	a_req_level: assert property (p_req_level) else $error("request with level off");
	a_no_portc_vec: assert property (p_no_portc_vec) else $error("port c vectored");
	a_read_answer: assert property (p_read_answer) else $error("read not answered");
	a_req_stays: assert property (p_req_stays) else $error("pending request lost");
	c_ack: cover property (i_irq_ack && o_core.req);
	c_lvl3: cover property (o_core.req && o_core.level == irp_pkg::IRP_LVL_3);
	c_read: cover property (i_arvalid && o_arready);
endmodule

bind irp_top irp_top_checker i_chk (.i_sys_clk, .i_nrst, .i_arvalid, .o_arready, .o_rvalid,
	.i_gie_set, .i_gie_clr, .i_irq_ack, .o_core, .o_global_int_enable);

// ---- testbench/irp_core_model.sv ----
// Purpose: behavioural processor core servicing vectored requests
// Assumes: acks after a set wait, re-enables as a return would
// Notes: log_q keeps every acknowledged vector
`timescale 1ns/1ps
module irp_core_model (
	input  wire logic                   i_sys_clk,
	input  wire logic                   i_nrst,
	input  wire irp_pkg::irp_core_req_t i_core,
	input  wire logic                   i_gie,
	input  wire logic                   i_run,
	input  wire logic [3:0]             i_wait,
	output logic                        o_irq_ack,
	output logic                        o_gie_set,
	output logic                        o_gie_clr
);
	logic [4:0] log_q[$];
	logic [3:0] cnt_r;
	logic       run_r;
	always @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_irq_ack <= 1'b0;
			o_gie_set <= 1'b0;
			o_gie_clr <= 1'b0;
			cnt_r     <= 4'h0;
			run_r     <= 1'b0;
		end else begin
			o_irq_ack <= 1'b0;
			o_gie_set <= 1'b0;
			o_gie_clr <= 1'b0;
			run_r     <= i_run;
			if (o_irq_ack && i_core.req)
				log_q.push_back(i_core.vec);
			if (run_r && !i_run)
				o_gie_clr <= 1'b1;
			else if (i_run && !i_gie && !o_gie_set)
				o_gie_set <= 1'b1;
			if (!i_core.req || o_irq_ack)
				cnt_r <= 4'h0;
			else if (cnt_r == i_wait)
				o_irq_ack <= 1'b1;
			else
				cnt_r <= cnt_r + 4'h1;
		end
	end
endmodule

// ---- testbench/tb_irp_top.sv ----
// Purpose: self-checking bench for the request/priority bank
// Assumes: core model services vectors, bench drives sources and bus
// Notes: byte address is index times four
`timescale 1ns/1ps
`include "irp_regs.svh"
module tb_irp_top;
	logic                   clk, nrst, awvalid, wvalid, bready, arvalid, rready;
	logic                   awready, wready, bvalid, arready, rvalid;
	logic                   gie, gset, gclr, ack, run;
	logic [15:0]            awaddr, araddr;
	logic [31:0]            wdata, rdata;
	logic [3:0]             wstrb, wt;
	logic [1:0]             bresp, rresp, bq;
	irp_pkg::irp_src_t      src;
	irp_pkg::irp_core_req_t core;
	int                     num_errors = 0;
	int                     checked = 0;
	int                     cyc = 0;

	irp_top #(.ADDR_W(16)) i_dut (
		.i_sys_clk(clk), .i_nrst(nrst), .i_awaddr(awaddr), .i_awvalid(awvalid),
		.o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
		.o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
		.i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
		.o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_src(src),
		.i_gie_set(gset), .i_gie_clr(gclr), .i_irq_ack(ack), .o_core(core),
		.o_global_int_enable(gie)
	);
	irp_core_model i_cpu (
		.i_sys_clk(clk), .i_nrst(nrst), .i_core(core), .i_gie(gie), .i_run(run),
		.i_wait(wt), .o_irq_ack(ack), .o_gie_set(gset), .o_gie_clr(gclr)
	);

	always #2.5 clk = ~clk;

	task automatic print_verdict();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			print_verdict();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] x, input logic [7:0] d);
		logic ta, tw, tb;
		tb = 1'b0;
		awaddr <= {2'h0, x, 2'h0};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!tb) begin
			@(negedge clk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			bq = bresp;
			@(posedge clk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
		end
	endtask

	task automatic rdchk(input logic [11:0] x, input logic [7:0] e, input logic [1:0] er);
		logic        t;
		logic [31:0] g;
		logic [1:0]  r;
		t = 1'b0;
		g = '0;
		r = '0;
		araddr <= {2'h0, x, 2'h0};
		arvalid <= 1'b1;
		while (!t) begin
			@(negedge clk);
			t = arready;
			@(posedge clk);
		end
		arvalid <= 1'b0;
		t = 1'b0;
		while (!t) begin
			@(negedge clk);
			t = rvalid;
			g = rdata;
			r = rresp;
			@(posedge clk);
		end
		chk(g, {24'h0, e});
		chk(r, er);
	endtask

	task automatic pulse(input logic [16:0] m);
		src <= irp_pkg::irp_src_t'(m);
		@(posedge clk);
		src <= '0;
	endtask

	task automatic t_regs();
		logic [11:0] ix[7] = '{`IRP_IDX_PEND0, `IRP_IDX_G0_HI, `IRP_IDX_G0_LO,
			`IRP_IDX_PEND1, `IRP_IDX_G1_HI, `IRP_IDX_G1_LO, `IRP_IDX_PEND2};
		logic [7:0] mk[7] = '{8'h79, 8'hff, 8'h79, 8'hff, 8'hff, 8'hff, 8'h0f};
		for (int i = 0; i < 7; i++) begin
			rdchk(ix[i], 8'h00, `IRP_RESP_OKAY);
			wr(ix[i], 8'hff);
			rdchk(ix[i], mk[i], `IRP_RESP_OKAY);
			wr(ix[i], 8'h00);
			rdchk(ix[i], 8'h00, `IRP_RESP_OKAY);
		end
		rdchk(12'hfc9, 8'h00, `IRP_RESP_SLVERR);
		wr(12'hfc9, 8'hff);
		chk(bq, `IRP_RESP_SLVERR);
		wr(`IRP_IDX_CTRL, 8'h80);
		chk(bq, `IRP_RESP_OKAY);
		rdchk(`IRP_IDX_CTRL, 8'h80, `IRP_RESP_OKAY);
		wr(`IRP_IDX_CTRL, 8'h00);
		rdchk(`IRP_IDX_CTRL, 8'h00, `IRP_RESP_OKAY);
		rdchk(`IRP_IDX_STAT, 8'h00, `IRP_RESP_OKAY);
		wstrb <= 4'h0;
		wr(`IRP_IDX_G1_HI, 8'hff);
		wstrb <= 4'h1;
		rdchk(`IRP_IDX_G1_HI, 8'h00, `IRP_RESP_OKAY);
	endtask

	task automatic t_capture();
		int pb[17] = '{6, 5, 4, 3, 0, 7, 6, 5, 4, 3, 2, 1, 0, 3, 2, 1, 0};
		logic [11:0] x;
		for (int k = 0; k < 17; k++) begin
			x = k < 5 ? `IRP_IDX_PEND0 : k < 13 ? `IRP_IDX_PEND1 : `IRP_IDX_PEND2;
			pulse(17'h1 << (16 - k));
			rdchk(x, 8'h1 << pb[k], `IRP_RESP_OKAY);
			chk(core.req, 1'b0);
			wr(x, 8'h00);
			rdchk(x, 8'h00, `IRP_RESP_OKAY);
		end
	endtask

	task automatic t_prio();
		wr(`IRP_IDX_G0_HI, 8'h01);
		wr(`IRP_IDX_G0_LO, 8'h41);
		wr(`IRP_IDX_G1_HI, 8'h81);
		wr(`IRP_IDX_G1_LO, 8'h80);
		pulse(17'h19810);
		@(posedge clk);
		rdchk(`IRP_IDX_STAT, 8'h64, `IRP_RESP_OKAY);
		chk(core.level, irp_pkg::IRP_LVL_3);
		chk(core.vec, 32'd4);
		i_cpu.log_q.delete();
		wt <= 4'h3;
		run <= 1'b1;
		while (i_cpu.log_q.size() < 4)
			@(negedge clk);
		@(posedge clk);
		run <= 1'b0;
		chk(i_cpu.log_q[0], 32'd4);
		chk(i_cpu.log_q[1], 32'd5);
		chk(i_cpu.log_q[2], 32'd12);
		chk(i_cpu.log_q[3], 32'd0);
		repeat (3) @(posedge clk);
		chk(gie, 1'b0);
		rdchk(`IRP_IDX_PEND0, 8'h20, `IRP_RESP_OKAY);
		rdchk(`IRP_IDX_PEND1, 8'h00, `IRP_RESP_OKAY);
		wr(`IRP_IDX_PEND0, 8'h00);
	endtask

	task automatic t_soft();
		wr(`IRP_IDX_G0_LO, 8'h00);
		wr(`IRP_IDX_G0_HI, 8'h20);
		wt <= 4'h0;
		run <= 1'b1;
		wr(`IRP_IDX_PEND0, 8'h20);
		while (i_cpu.log_q.size() < 5)
			@(negedge clk);
		@(posedge clk);
		run <= 1'b0;
		chk(i_cpu.log_q[4], 32'd1);
		rdchk(`IRP_IDX_PEND0, 8'h00, `IRP_RESP_OKAY);
	endtask

	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		{awvalid, wvalid, arvalid, run} = '0;
		{awaddr, araddr, wdata, wt} = '0;
		{bready, rready} = 2'h3;
		wstrb = 4'h1;
		src = '0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_regs();
		t_capture();
		t_prio();
		t_soft();
		print_verdict();
	end
endmodule
